/* File: logic/cipg_gate.sv */
`timescale 1ns/1ps
module cipg_gate
#(
   parameter int         ACT_DEPTH       = 4,
   parameter logic [7:0] LEGACY_IDLE     = 8'hff,
   parameter logic       HAS_TRANSLATION = 1'b1
)
(
   // clock and reset
   input  wire logic                         I_REF_CLK,
   input  wire logic                         I_RST,
   // configuration
   input  wire logic [7:0]                   I_PRIORITY_MASK,
   input  wire logic [2:0]                   I_BINARY_POINT_G0,
   input  wire logic [2:0]                   I_BINARY_POINT_G1,
   input  wire logic                         I_LEGACY_MODE,
   input  wire logic                         I_AFFINITY_EN,
   input  wire logic                         I_SYSREG_EN,
   input  wire logic                         I_SHARED_MSG_LEVEL,
   // highest pending candidate
   input  wire logic                         I_PEND_VALID,
   input  wire logic                         I_PEND_ENABLE,
   input  wire logic [cipg_pkg::ID_W-1:0]    I_PEND_ID,
   input  wire logic [7:0]                   I_PEND_PRIO,
   input  wire logic                         I_PEND_GROUP,
   // processing element actions
   input  wire logic                         I_ACK,
   input  wire logic                         I_PRIO_DROP,
   input  wire logic                         I_DEACT,
   input  wire logic [cipg_pkg::ID_W-1:0]    I_DEACT_ID,
   // message writes
   input  wire logic                         I_MSG_WR_VALID,
   input  wire logic [cipg_pkg::ADDR_W-1:0]  I_MSG_WR_ADDR,
   input  wire logic [cipg_pkg::ID_W-1:0]    I_MSG_WR_ID,
   // priority status
   output logic      [7:0]                   O_RUNNING_PRIORITY_REG,
   output logic      [7:0]                   O_LEGACY_RUNNING_PRIORITY_REG,
   output logic                              O_CONFIG_UNPREDICTABLE,
   // signal to processing element
   output logic                              O_SIGNAL_IRQ,
   output logic      [cipg_pkg::ID_W-1:0]    O_SIGNAL_ID,
   output logic      [7:0]                   O_SIGNAL_PRIO,
   output logic                              O_SIGNAL_GROUP,
   output logic                              O_SIGNAL_PER_ELEM,
   // message results
   output logic                              O_MSG_ASSERT,
   output cipg_pkg::cipg_msg_kind_t          O_MSG_KIND,
   output logic      [cipg_pkg::ID_W-1:0]    O_MSG_ID,
   output logic                              O_SHARED_MSG_LEVEL
);

   localparam int IDX_W = (ACT_DEPTH > 1) ? $clog2(ACT_DEPTH) : 1;
   localparam int CNT_W = $clog2(ACT_DEPTH + 1);

   //----------------------------------------
   // active slots
   //----------------------------------------
   logic [ACT_DEPTH-1:0]       slot_valid;
   logic [ACT_DEPTH-1:0]       slot_dropped;
   logic [7:0]                 slot_prio [ACT_DEPTH];
   logic [cipg_pkg::ID_W-1:0]  slot_id   [ACT_DEPTH];

   logic                       live_any;
   logic [CNT_W-1:0]           live_cnt;
   logic [7:0]                 min_live;
   logic [IDX_W-1:0]           drop_idx;
   logic                       free_any;
   logic [IDX_W-1:0]           free_idx;
   logic                       deact_hit;
   logic [IDX_W-1:0]           deact_idx;
   logic [7:0]                 next_running;
   logic                       take_ack;
   logic                       push_active;
   logic [2:0]                 sig_bp;
   logic [7:0]                 sig_grp_prio;
   logic                       qualify;
   logic [cipg_pkg::ADDR_W-1:0] local_addr;

   cipg_cmp_if cmp_bus ();

   cipg_prio_cmp u_cmp
   (
      .cmp (cmp_bus.checker_side)
   );

   assign cmp_bus.cand_prio  = I_PEND_PRIO;
   assign cmp_bus.cand_group = I_PEND_GROUP;
   assign cmp_bus.bp0        = I_BINARY_POINT_G0;
   assign cmp_bus.bp1        = I_BINARY_POINT_G1;
   assign cmp_bus.mask_prio  = I_PRIORITY_MASK;
   assign cmp_bus.running    = O_RUNNING_PRIORITY_REG;

   //----------------------------------------
   // slot scan
   //----------------------------------------
   always_comb
   begin
      live_any  = 1'b0;
      live_cnt  = '0;
      min_live  = cipg_pkg::IDLE_PRIO;
      drop_idx  = '0;
      free_any  = 1'b0;
      free_idx  = '0;
      deact_hit = 1'b0;
      deact_idx = '0;
      for (int i = 0; i < ACT_DEPTH; i++)
      begin
         if (slot_valid[i] && !slot_dropped[i])
         begin
            live_cnt = live_cnt + CNT_W'(1);
            if (!live_any || slot_prio[i] < min_live)
            begin
               min_live = slot_prio[i];
               drop_idx = IDX_W'(i);
            end
            live_any = 1'b1;
         end
         if (!slot_valid[i] && !free_any)
         begin
            free_any = 1'b1;
            free_idx = IDX_W'(i);
         end
         if (slot_valid[i] && slot_id[i] == I_DEACT_ID && !deact_hit)
         begin
            deact_hit = 1'b1;
            deact_idx = IDX_W'(i);
         end
      end
   end

   assign next_running = live_any ? min_live : cipg_pkg::IDLE_PRIO;

   assign take_ack     = I_ACK && O_SIGNAL_IRQ;
   assign sig_bp       = O_SIGNAL_GROUP ? I_BINARY_POINT_G1 : I_BINARY_POINT_G0;
   assign sig_grp_prio = cipg_pkg::group_prio(O_SIGNAL_PRIO, sig_bp);
   // local interrupts never enter a slot
   assign push_active  = take_ack && !cipg_pkg::is_local_id(O_SIGNAL_ID) && free_any;

   always_ff @(posedge I_REF_CLK)
   begin
      if (I_RST)
      begin
         slot_valid   <= '0;
         slot_dropped <= '0;
         for (int i = 0; i < ACT_DEPTH; i++)
         begin
            slot_prio[i] <= cipg_pkg::IDLE_PRIO;
            slot_id[i]   <= '0;
         end
      end
      else
      begin
         for (int i = 0; i < ACT_DEPTH; i++)
         begin
            if (push_active && free_idx == IDX_W'(i))
            begin
               slot_valid[i]   <= 1'b1;
               slot_dropped[i] <= 1'b0;
               slot_prio[i]    <= sig_grp_prio;
               slot_id[i]      <= O_SIGNAL_ID;
            end
            else if (I_DEACT && deact_hit && deact_idx == IDX_W'(i))
            begin
               slot_valid[i]   <= 1'b0;
               slot_dropped[i] <= 1'b0;
            end
            else if (I_PRIO_DROP && live_any && drop_idx == IDX_W'(i))
            begin
               slot_dropped[i] <= 1'b1;
            end
         end
      end
   end

   //----------------------------------------
   // running priority registers
   //----------------------------------------
   always_ff @(posedge I_REF_CLK)
   begin
      if (I_RST)
      begin
         O_RUNNING_PRIORITY_REG        <= cipg_pkg::IDLE_PRIO;
         O_LEGACY_RUNNING_PRIORITY_REG <= LEGACY_IDLE;
      end
      else
      begin
         O_RUNNING_PRIORITY_REG        <= next_running;
         O_LEGACY_RUNNING_PRIORITY_REG <= live_any ? min_live : LEGACY_IDLE;
      end
   end

   always_ff @(posedge I_REF_CLK)
   begin
      if (I_RST)
         O_CONFIG_UNPREDICTABLE <= 1'b0;
      else
         O_CONFIG_UNPREDICTABLE <= I_AFFINITY_EN && !I_SYSREG_EN;
   end

   //----------------------------------------
   // signaling
   //----------------------------------------
   // all comparisons must pass
   assign qualify = I_PEND_VALID && I_PEND_ENABLE && cmp_bus.sufficient && !take_ack;

   always_ff @(posedge I_REF_CLK)
   begin
      if (I_RST)
      begin
         O_SIGNAL_IRQ    <= 1'b0;
         O_SIGNAL_ID     <= '0;
         O_SIGNAL_PRIO   <= cipg_pkg::IDLE_PRIO;
         O_SIGNAL_GROUP  <= 1'b0;
         O_SIGNAL_PER_ELEM <= 1'b0;
      end
      else
      begin
         O_SIGNAL_IRQ    <= qualify;
         O_SIGNAL_ID     <= I_PEND_ID;
         O_SIGNAL_PRIO   <= I_PEND_PRIO;
         O_SIGNAL_GROUP  <= I_PEND_GROUP;
         O_SIGNAL_PER_ELEM <= cipg_pkg::is_per_elem(I_PEND_ID);
      end
   end

   //----------------------------------------
   // message writes
   //----------------------------------------
   // local message address
   assign local_addr = HAS_TRANSLATION ? cipg_pkg::LOC_TRANS_ADDR : cipg_pkg::LOC_RDIST_ADDR;

   always_ff @(posedge I_REF_CLK)
   begin
      if (I_RST)
      begin
         O_MSG_ASSERT       <= 1'b0;
         O_MSG_KIND         <= cipg_pkg::MSG_NONE;
         O_MSG_ID           <= '0;
         O_SHARED_MSG_LEVEL <= 1'b0;
      end
      else
      begin
         O_MSG_ASSERT <= 1'b0;
         O_MSG_KIND   <= cipg_pkg::MSG_NONE;
         if (I_MSG_WR_VALID && I_MSG_WR_ADDR == cipg_pkg::SHARED_SET_ADDR)
         begin
            O_MSG_ASSERT       <= 1'b1;
            O_MSG_KIND         <= cipg_pkg::MSG_SHARED;
            O_MSG_ID           <= I_MSG_WR_ID;
            O_SHARED_MSG_LEVEL <= I_SHARED_MSG_LEVEL;
         end
         else if (I_MSG_WR_VALID && I_MSG_WR_ADDR == cipg_pkg::SHARED_CLR_ADDR)
            O_SHARED_MSG_LEVEL <= 1'b0;
         else if (I_MSG_WR_VALID && I_MSG_WR_ADDR == local_addr
                  && cipg_pkg::is_local_id(I_MSG_WR_ID))
         begin
            O_MSG_ASSERT <= 1'b1;
            O_MSG_KIND   <= cipg_pkg::MSG_LOCAL;
            O_MSG_ID     <= I_MSG_WR_ID;
         end
      end
   end

   //----------------------------------------
   // checks
   //----------------------------------------
   chk_idle_value: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
      !live_any |=> O_RUNNING_PRIORITY_REG == cipg_pkg::IDLE_PRIO)
      else $error("running priority not idle with no live slot");

   chk_run_active: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
      live_any |=> O_RUNNING_PRIORITY_REG == $past(min_live))
      else $error("running priority differs from live group priority");

   chk_drop_count: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
      (I_PRIO_DROP && live_any && !I_DEACT && !push_active)
      |=> live_cnt == $past(live_cnt) - CNT_W'(1))
      else $error("priority drop did not retire one live slot");

   chk_legacy_idle: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
      !live_any |=> O_LEGACY_RUNNING_PRIORITY_REG == LEGACY_IDLE)
      else $error("legacy idle value wrong");

   chk_mask_gate: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
      O_SIGNAL_IRQ |-> O_SIGNAL_PRIO < $past(I_PRIORITY_MASK))
      else $error("signaled interrupt not above priority mask");

   chk_preempt_only: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
      O_SIGNAL_IRQ |-> $past(cmp_bus.cand_grp_prio) < $past(O_RUNNING_PRIORITY_REG))
      else $error("signaled interrupt does not preempt");

   chk_signal_cause: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
      ##1 O_SIGNAL_IRQ == $past(I_PEND_VALID && I_PEND_ENABLE
                                && I_PEND_PRIO < I_PRIORITY_MASK
                                && cipg_pkg::group_prio(I_PEND_PRIO, I_PEND_GROUP ?
                                   I_BINARY_POINT_G1 : I_BINARY_POINT_G0) < O_RUNNING_PRIORITY_REG
                                && !take_ack))
      else $error("signal does not follow sufficiency");

   chk_msg_shared: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
      (I_MSG_WR_VALID && I_MSG_WR_ADDR == cipg_pkg::SHARED_SET_ADDR)
      |=> O_MSG_ASSERT && O_MSG_KIND == cipg_pkg::MSG_SHARED)
      else $error("shared message write not asserted");

   chk_local_noactive: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
      (take_ack && cipg_pkg::is_local_id(O_SIGNAL_ID) && !I_DEACT && !I_PRIO_DROP)
      |=> slot_valid == $past(slot_valid))
      else $error("local interrupt took an active slot");

endmodule

/* File: logic/cipg_pkg.sv */
// How it works
// - no active interrupt: running priority reads idle value 0xff
// - running priority is group priority of active, undropped interrupt
// - all active interrupts dropped: running priority returns to 0xff
// - legacy running priority idle value is implementation defined
// - pending interrupt priority must beat the priority mask
// - group 0 and group 1 binary points set preemption grouping
// - candidate group priority must beat running priority to preempt
// - only an interrupt passing every comparison is signaled
// - message interrupt asserted by write to its assigned address
// - shared messages use distributor address, level or edge behaviour
// - local messages always edge; address in translation unit else redistributor
// - private and software ids are per element; others global
// - local interrupts have no active state; acknowledge makes them inactive
package cipg_pkg;

   localparam int          PRIO_W          = 8;
   localparam int          BP_W            = 3;
   localparam int          ID_W            = 16;
   localparam int          ADDR_W          = 32;

   localparam logic [7:0]  IDLE_PRIO       = 8'hff;
   localparam logic [7:0]  PRIO_ALL_ONES   = 8'hff;
   localparam logic [3:0]  BP_SHIFT_BIAS   = 4'h1;

   // identifier ranges
   localparam logic [15:0] SOFT_ID_LAST    = 16'h000f;
   localparam logic [15:0] PRIV_ID_LAST    = 16'h001f;
   localparam logic [15:0] LOCAL_ID_BASE   = 16'h2000;

   // assigned message addresses
   localparam logic [31:0] SHARED_SET_ADDR = 32'h0000_0040;
   localparam logic [31:0] SHARED_CLR_ADDR = 32'h0000_0048;
   localparam logic [31:0] LOC_TRANS_ADDR  = 32'h0001_0040;
   localparam logic [31:0] LOC_RDIST_ADDR  = 32'h0002_0040;

   typedef enum logic [1:0]
   {
      MSG_NONE   = 2'b00,
      MSG_SHARED = 2'b01,
      MSG_LOCAL  = 2'b10
   } cipg_msg_kind_t;

   // preemption part of a priority for a binary point
   function automatic logic [7:0] group_prio(input logic [7:0] prio, input logic [2:0] bp);
      logic [7:0] msk;
      msk = PRIO_ALL_ONES << ({1'b0, bp} + BP_SHIFT_BIAS);
      return prio & msk;
   endfunction

   function automatic logic is_local_id(input logic [15:0] id);
      return id >= LOCAL_ID_BASE;
   endfunction

   function automatic logic is_per_elem(input logic [15:0] id);
      return id <= PRIV_ID_LAST;
   endfunction

endpackage

/* File: logic/cipg_cmp_if.sv */
`timescale 1ns/1ps
interface cipg_cmp_if;
   logic [7:0] cand_prio;
   logic       cand_group;
   logic [2:0] bp0;
   logic [2:0] bp1;
   logic [7:0] mask_prio;
   logic [7:0] running;
   logic       sufficient;
   logic [7:0] cand_grp_prio;

   modport requester
   (
      output cand_prio,
      output cand_group,
      output bp0,
      output bp1,
      output mask_prio,
      output running,
      input  sufficient,
      input  cand_grp_prio
   );

   modport checker_side
   (
      input  cand_prio,
      input  cand_group,
      input  bp0,
      input  bp1,
      input  mask_prio,
      input  running,
      output sufficient,
      output cand_grp_prio
   );
endinterface

/* File: logic/cipg_prio_cmp.sv */
`timescale 1ns/1ps
module cipg_prio_cmp
(
   // comparison request and result
   cipg_cmp_if.checker_side cmp
);

   logic [2:0] sel_bp;
   logic       beats_mask;
   logic       beats_running;

   //----------------------------------------
   // sufficiency comparison
   //----------------------------------------
   always_comb
   begin
      sel_bp            = cmp.cand_group ? cmp.bp1 : cmp.bp0;
      cmp.cand_grp_prio = cipg_pkg::group_prio(cmp.cand_prio, sel_bp);
      beats_mask        = cmp.cand_prio < cmp.mask_prio;
      beats_running     = cmp.cand_grp_prio < cmp.running;
      cmp.sufficient    = beats_mask && beats_running;
   end

endmodule

/* File: verif/cipg_pe_model.sv */
`timescale 1ns/1ps
module cipg_elem_model
(
   // clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   // bench control
   input  wire logic       i_auto_ack,
   input  wire logic [3:0] i_ack_delay,
   input  wire logic       i_affinity,
   input  wire logic       i_misconfig,
   // interface side
   input  wire logic       i_irq,
   output logic            o_ack,
   output logic            o_sysreg_en
);
   logic [3:0] wait_cnt;

   assign o_sysreg_en = i_affinity & !i_misconfig;

   // acks a signaled interrupt after a delay, one cycle pulse
   always @(negedge i_clk)
   begin
      o_ack <= 1'b0;
      if (i_rst || !i_irq || !i_auto_ack || o_ack)
         wait_cnt <= 4'h0;
      else if (wait_cnt == i_ack_delay)
         o_ack <= 1'b1;
      else
         wait_cnt <= wait_cnt + 4'h1;
   end
endmodule

/* File: verif/tb_cipg_gate.sv */
`timescale 1ns/1ps
module tb_cipg_gate;
   typedef struct packed
   {
      logic [7:0]  mask;
      logic [2:0]  bp0;
      logic [2:0]  bp1;
      logic [7:0]  prio;
      logic        grp;
      logic [1:0]  ven;
      logic [15:0] id;
      logic        irq;
   } cipg_row_t;

   // ----------------------------------------
   // rows: idle first, then running at 0x40
   // ----------------------------------------
   cipg_row_t rows[13] = '{
      '{8'h80, 3'h3, 3'h3, 8'h40, 1'h0, 2'h3, 16'h001f, 1'h1},
      '{8'h80, 3'h3, 3'h3, 8'h80, 1'h0, 2'h3, 16'h0020, 1'h0},
      '{8'h80, 3'h3, 3'h3, 8'h7f, 1'h1, 2'h3, 16'h0020, 1'h1},
      '{8'h80, 3'h3, 3'h3, 8'h40, 1'h0, 2'h1, 16'h0010, 1'h0},
      '{8'h80, 3'h3, 3'h3, 8'h40, 1'h0, 2'h2, 16'h0010, 1'h0},
      '{8'hff, 3'h7, 3'h7, 8'hfe, 1'h1, 2'h3, 16'h0005, 1'h1},
      '{8'hff, 3'h0, 3'h0, 8'hff, 1'h0, 2'h3, 16'h0005, 1'h0},
      '{8'hff, 3'h3, 3'h3, 8'h48, 1'h0, 2'h3, 16'h0030, 1'h0},
      '{8'hff, 3'h3, 3'h3, 8'h3f, 1'h0, 2'h3, 16'h0030, 1'h1},
      '{8'hff, 3'h7, 3'h0, 8'h41, 1'h1, 2'h3, 16'h0030, 1'h0},
      '{8'hff, 3'h7, 3'h0, 8'h3f, 1'h1, 2'h3, 16'h0030, 1'h1},
      '{8'hff, 3'h0, 3'h7, 8'h41, 1'h0, 2'h3, 16'h0030, 1'h0},
      '{8'h30, 3'h3, 3'h3, 8'h3f, 1'h0, 2'h3, 16'h0030, 1'h0}};
   logic [31:0] m_addr[7] = '{32'h40, 32'h48, 32'h10040, 32'h10040, 32'h20040, 32'h44, 32'h40};
   logic [15:0] m_id[7]   = '{16'h30, 16'h30, 16'h2000, 16'h1fff, 16'h2005, 16'h30, 16'h31};
   logic [1:0]  m_kind[7] = '{2'h1, 2'h0, 2'h2, 2'h0, 2'h0, 2'h0, 2'h1};
   logic        m_lvl[7]  = '{1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 1'h0};
   logic        m_out[7]  = '{1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0};

   logic        clk, rst, lmode, aff, misc, lvl_in, pv, pen, grp, drop, deact, mwv, auto_ack;
   logic [7:0]  mask, prio, rp, lrp, sprio;
   logic [2:0]  bp0, bp1;
   logic [3:0]  dly;
   logic [15:0] pid, did, mid, sid, mout;
   logic [31:0] maddr;
   logic        ack, sysreg, unp, irq, sgrp, per_elem, massert, mlvl;
   cipg_pkg::cipg_msg_kind_t mkind;
   int          mismatches;
   int          samples_checked;

   cipg_gate #(.LEGACY_IDLE(8'h5a)) u_cipg_gate
   (
      .I_REF_CLK(clk), .I_RST(rst), .I_PRIORITY_MASK(mask), .I_BINARY_POINT_G0(bp0),
      .I_BINARY_POINT_G1(bp1), .I_LEGACY_MODE(lmode), .I_AFFINITY_EN(aff),
      .I_SYSREG_EN(sysreg), .I_SHARED_MSG_LEVEL(lvl_in), .I_PEND_VALID(pv),
      .I_PEND_ENABLE(pen), .I_PEND_ID(pid), .I_PEND_PRIO(prio), .I_PEND_GROUP(grp),
      .I_ACK(ack), .I_PRIO_DROP(drop), .I_DEACT(deact), .I_DEACT_ID(did),
      .I_MSG_WR_VALID(mwv), .I_MSG_WR_ADDR(maddr), .I_MSG_WR_ID(mid),
      .O_RUNNING_PRIORITY_REG(rp), .O_LEGACY_RUNNING_PRIORITY_REG(lrp),
      .O_CONFIG_UNPREDICTABLE(unp), .O_SIGNAL_IRQ(irq), .O_SIGNAL_ID(sid),
      .O_SIGNAL_PRIO(sprio), .O_SIGNAL_GROUP(sgrp), .O_SIGNAL_PER_ELEM(per_elem),
      .O_MSG_ASSERT(massert), .O_MSG_KIND(mkind), .O_MSG_ID(mout),
      .O_SHARED_MSG_LEVEL(mlvl)
   );

   cipg_elem_model u_cipg_elem_model
   (
      .i_clk(clk), .i_rst(rst), .i_auto_ack(auto_ack), .i_ack_delay(dly),
      .i_affinity(aff), .i_misconfig(misc), .i_irq(irq), .o_ack(ack),
      .o_sysreg_en(sysreg)
   );

   initial
   begin
      clk = 1'b1;
      forever #20 clk = ~clk;
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic run_row(input int i);
      {mask, bp0, bp1, prio, grp} <= {rows[i].mask, rows[i].bp0, rows[i].bp1, rows[i].prio,
                                      rows[i].grp};
      {pv, pen} <= rows[i].ven;
      pid <= rows[i].id;
      tick(2);
      check(16'(irq), 16'(rows[i].irq));
      check(sid, rows[i].id);
      check(16'(sprio), 16'(rows[i].prio));
      check(16'(sgrp), 16'(rows[i].grp));
      if (rows[i].irq)
         check(16'(per_elem), 16'(rows[i].id <= 16'h001f));
   endtask

   // signal a candidate and let the element take it
   task automatic take(input logic [7:0] p, input logic [15:0] id);
      int n;
      n = 0;
      {mask, bp0, prio, grp, pid, pv, pen, auto_ack} <= {8'hff, 3'h3, p, 1'b0, id, 3'h7};
      tick(1);
      while (ack !== 1'b1 && n < 20)
      begin
         tick(1);
         n++;
      end
      check(16'(irq), 16'h0);
      {auto_ack, pv} <= 2'h0;
      tick(3);
   endtask

   task automatic pulse_drop();
      drop <= 1'b1;
      tick(1);
      drop <= 1'b0;
      tick(2);
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   initial
   begin
      #(40 * 4000);
      mismatches++;
      test_done();
   end

   initial
   begin
      {rst, lmode, aff, misc, lvl_in, pv, pen, grp, drop, deact, mwv, auto_ack} = 12'ha00;
      {mask, prio, bp0, bp1, dly, pid, did, mid, maddr} = '0;
      mismatches = 0;
      samples_checked = 0;
      tick(5);
      rst <= 1'b0;
      tick(1);
      check(16'(rp), 16'hff);
      check(16'(lrp), 16'h5a);
      for (int i = 0; i < 7; i++)
         run_row(i);
      dly <= 4'h2;
      take(8'h40, 16'h0030);
      check(16'(rp), 16'h40);
      check(16'(lrp), 16'h40);
      for (int i = 7; i < 13; i++)
         run_row(i);
      take(8'h20, 16'h0031);
      check(16'(rp), 16'h20);
      pulse_drop();
      check(16'(rp), 16'h40);
      lmode <= 1'b1;
      pulse_drop();
      check(16'(rp), 16'hff);
      check(16'(lrp), 16'h5a);
      deact <= 1'b1;
      for (int i = 0; i < 2; i++)
      begin
         did <= 16'h0030 + 16'(i);
         tick(1);
      end
      deact <= 1'b0;
      dly <= 4'h0;
      take(8'h10, 16'h2000);
      check(16'(rp), 16'hff);
      take(8'h40, 16'h0032);
      check(16'(rp), 16'h40);
      take(8'h30, 16'h0033);
      check(16'(rp), 16'h30);
      {did, deact} <= {16'h0033, 1'b1};
      tick(1);
      deact <= 1'b0;
      tick(2);
      check(16'(rp), 16'h40);
      rst <= 1'b1;
      tick(1);
      rst <= 1'b0;
      tick(1);
      check(16'(rp), 16'hff);
      mwv <= 1'b1;
      for (int i = 0; i < 7; i++)
      begin
         {maddr, mid, lvl_in} <= {m_addr[i], m_id[i], m_lvl[i]};
         tick(1);
         check(16'(massert), 16'(m_kind[i] != 2'h0));
         check(16'(mkind), 16'(m_kind[i]));
         check(16'(mlvl), 16'(m_out[i]));
         if (m_kind[i] != 2'h0)
            check(mout, m_id[i]);
      end
      mwv <= 1'b0;
      misc <= 1'b1;
      tick(2);
      check(16'(unp), 16'h1);
      aff <= 1'b0;
      tick(2);
      check(16'(unp), 16'h0);
      test_done();
   end
endmodule
